/* File: verif/cbx_exec_tb.sv */
// self-checking testbench for the bit/logic/call execute block
`timescale 1ns/1ps

module testbench;

  // ---------------------------------------------------------------------------
  // design signals
  // ---------------------------------------------------------------------------
  logic                             clk;
  logic                             rst;
  logic                             instr_valid;
  cbx_pkg::cbx_op_e                 instr_op;
  logic [cbx_pkg::FADDR_W-1:0]      instr_faddr;
  logic [cbx_pkg::BIT_W-1:0]        instr_bit;
  logic                             instr_dest;
  logic [cbx_pkg::DATA_W-1:0]       instr_literal;
  logic [cbx_pkg::TARGET_W-1:0]     instr_target;
  logic [cbx_pkg::FADDR_W-1:0]      file_raddr;
  logic [cbx_pkg::DATA_W-1:0]       file_rdata;
  logic                             file_we;
  logic [cbx_pkg::FADDR_W-1:0]      file_waddr;
  logic [cbx_pkg::DATA_W-1:0]       file_wdata;
  logic [cbx_pkg::DATA_W-1:0]       upper_jump_latch;
  logic                             acc_load;
  logic [cbx_pkg::DATA_W-1:0]       acc_load_data;
  logic [cbx_pkg::DATA_W-1:0]       acc_q;
  logic [cbx_pkg::PC_W-1:0]         pc_q;
  logic                             result_null_flag_q;
  logic                             watchdog_expired_flag_q;
  logic                             sleep_entered_flag_q;
  logic                             stack_push;
  logic [cbx_pkg::PC_W-1:0]         stack_top;
  logic                             watchdog_counter_clr;
  logic                             watchdog_prescaler_clr;
  logic [cbx_pkg::DATA_W-1:0]       watchdog_counter_load;
  logic                             flush_q;
  int                               failures;
  int                               samples_checked;
  // expected architectural state, worked out from the instruction semantics
  logic [7:0]                       e_acc;
  logic [12:0]                      e_pc;
  logic [12:0]                      e_top;
  logic                             e_z;
  logic                             e_flush;

  cbx_exec u_cbx_exec (
    .clk                    (clk),
    .rst                    (rst),
    .instr_valid            (instr_valid),
    .instr_op               (instr_op),
    .instr_faddr            (instr_faddr),
    .instr_bit              (instr_bit),
    .instr_dest             (instr_dest),
    .instr_literal          (instr_literal),
    .instr_target           (instr_target),
    .file_raddr             (file_raddr),
    .file_rdata             (file_rdata),
    .file_we                (file_we),
    .file_waddr             (file_waddr),
    .file_wdata             (file_wdata),
    .upper_jump_latch       (upper_jump_latch),
    .acc_load               (acc_load),
    .acc_load_data          (acc_load_data),
    .acc_q                  (acc_q),
    .pc_q                   (pc_q),
    .result_null_flag_q     (result_null_flag_q),
    .watchdog_expired_flag_q(watchdog_expired_flag_q),
    .sleep_entered_flag_q   (sleep_entered_flag_q),
    .stack_push             (stack_push),
    .stack_top              (stack_top),
    .watchdog_counter_clr   (watchdog_counter_clr),
    .watchdog_prescaler_clr (watchdog_prescaler_clr),
    .watchdog_counter_load  (watchdog_counter_load),
    .flush_q                (flush_q)
  );

  // 200 MHz clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // ---------------------------------------------------------------------------
  // compare, verdict and hang guard
  // ---------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a stuck run is cut short and counted as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    conclude();
  end

  // ---------------------------------------------------------------------------
  // access tasks, entered at a falling edge
  // ---------------------------------------------------------------------------
  task automatic do_reset(input int cycles);
    rst = 1'b1;
    instr_valid = 1'b0;
    repeat (cycles) @(negedge clk);
    check(acc_q, 8'h00, "reset accumulator");
    check(pc_q, 13'h0000, "reset pc");
    check(result_null_flag_q, 1'b0, "reset zero flag");
    check(watchdog_expired_flag_q, 1'b1, "reset expired flag");
    check(sleep_entered_flag_q, 1'b1, "reset sleep flag");
    check({file_we, stack_push, watchdog_counter_clr, flush_q}, 4'h0, "reset strobes");
    check(stack_top, 13'h0000, "reset stack top");
    rst = 1'b0;
    e_acc = 8'h00;
    e_pc = 13'h0000;
    e_top = 13'h0000;
    e_z = 1'b0;
    e_flush = 1'b0;
  endtask

  // accumulator write-back from outside, in an empty unsquashed slot
  task automatic load_acc(input logic [7:0] v);
    instr_valid = 1'b0;
    acc_load = 1'b1;
    acc_load_data = v;
    @(posedge clk);
    @(negedge clk);
    acc_load = 1'b0;
    e_acc = v;
    e_flush = 1'b0;
  endtask

  // present one instruction slot, predict its effect, check one cycle later
  task automatic run(input cbx_pkg::cbx_op_e op, input logic v, input logic [6:0] fa,
                     input logic [2:0] b, input logic d, input logic [7:0] k,
                     input logic [10:0] t, input logic [7:0] rd, input logic [7:0] ujl);
    logic       live;
    logic       we;
    logic       push;
    logic       kick;
    logic       nflush;
    logic [7:0] wd;
    live = v && !e_flush;
    we = 1'b0;
    push = 1'b0;
    kick = 1'b0;
    nflush = 1'b0;
    wd = 8'h00;
    instr_valid = v;
    instr_op = op;
    instr_faddr = fa;
    instr_bit = b;
    instr_dest = d;
    instr_literal = k;
    instr_target = t;
    file_rdata = rd;
    upper_jump_latch = ujl;
    #1;
    check(file_raddr, fa, "read address");
    if (live) begin
      case (op)
        cbx_pkg::CBX_OP_SET_BIT: begin
          we = 1'b1;
          wd = rd | (8'h01 << b);
        end
        cbx_pkg::CBX_OP_AND_IMM: begin
          e_acc = e_acc & k;
          e_z = (e_acc == 8'h00);
        end
        cbx_pkg::CBX_OP_AND_FILE: begin
          wd = e_acc & rd;
          e_z = (wd == 8'h00);
          we = d;
          if (!d) e_acc = wd;
        end
        cbx_pkg::CBX_OP_SKIP_CLR: nflush = !rd[b];
        cbx_pkg::CBX_OP_SKIP_SET: nflush = rd[b];
        cbx_pkg::CBX_OP_WDT_KICK: kick = 1'b1;
        cbx_pkg::CBX_OP_CALL: begin
          push = 1'b1;
          nflush = 1'b1;
          e_top = e_pc + 13'h0001;
        end
        default: ;
      endcase
    end
    e_pc = (live && op == cbx_pkg::CBX_OP_CALL) ? {ujl[4:3], t} :
           (v || e_flush) ? e_pc + 13'h0001 : e_pc;
    e_flush = nflush;
    @(posedge clk);
    @(negedge clk);
    check(acc_q, e_acc, "accumulator");
    check(pc_q, e_pc, "program counter");
    check(result_null_flag_q, e_z, "zero flag");
    check(watchdog_expired_flag_q, 1'b1, "expired flag");
    check(sleep_entered_flag_q, 1'b1, "sleep flag");
    check(file_we, we, "file write strobe");
    if (we) begin
      check(file_waddr, fa, "write address");
      check(file_wdata, wd, "write data");
    end
    check(stack_push, push, "stack push");
    check(stack_top, e_top, "return address");
    check({watchdog_counter_clr, watchdog_prescaler_clr}, {kick, kick}, "kick clears");
    check(watchdog_counter_load, 8'h00, "counter load");
    check(flush_q, nflush, "squash marker");
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    failures = 0;
    samples_checked = 0;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_op = cbx_pkg::CBX_OP_NOP;
    instr_faddr = 7'h00;
    instr_bit = 3'h0;
    instr_dest = 1'b0;
    instr_literal = 8'h00;
    instr_target = 11'h000;
    file_rdata = 8'h00;
    upper_jump_latch = 8'h00;
    acc_load = 1'b0;
    acc_load_data = 8'h00;
    @(negedge clk);
    do_reset(16);
    // every bit index, even ones at address 00 and odd ones at 7f, zero flag still clear
    for (int i = 0; i < 16; i++) begin
      run(cbx_pkg::CBX_OP_SET_BIT, 1'b1, i[0] ? 7'h7f : 7'h00, i[2:0], 1'b0, 8'h00, 11'h000,
          i[3] ? 8'h00 : ~(8'h01 << i[2:0]), 8'h00);
    end
    // AND forms, back to back; both destinations
    load_acc(8'h5a);
    run(cbx_pkg::CBX_OP_AND_IMM, 1'b1, 7'h00, 3'h0, 1'b0, 8'hff, 11'h000, 8'h00, 8'h00);
    run(cbx_pkg::CBX_OP_AND_FILE, 1'b1, 7'h12, 3'h0, 1'b1, 8'h00, 11'h000, 8'h0f, 8'h00);
    run(cbx_pkg::CBX_OP_AND_FILE, 1'b1, 7'h7f, 3'h0, 1'b0, 8'h00, 11'h000, 8'hf0, 8'h00);
    run(cbx_pkg::CBX_OP_AND_IMM, 1'b1, 7'h00, 3'h0, 1'b0, 8'h00, 11'h000, 8'h00, 8'h00);
    // bit set leaves a set zero flag alone
    run(cbx_pkg::CBX_OP_SET_BIT, 1'b1, 7'h33, 3'h7, 1'b0, 8'h00, 11'h000, 8'h80, 8'h00);
    // both skips, tested bit low and high, followed by a file write
    for (int i = 0; i < 4; i++) begin
      run(i[1] ? cbx_pkg::CBX_OP_SKIP_SET : cbx_pkg::CBX_OP_SKIP_CLR, 1'b1, 7'h05, 3'(i + 4),
          1'b0, 8'h00, 11'h000, i[0] ? (8'h01 << (i + 4)) : ~(8'h01 << (i + 4)), 8'h00);
      run(cbx_pkg::CBX_OP_AND_FILE, 1'b1, 7'h06, 3'h0, 1'b1, 8'h00, 11'h000, 8'hff, 8'h00);
    end
    // skip taken, then a skip in the squashed slot must not squash again
    run(cbx_pkg::CBX_OP_SKIP_SET, 1'b1, 7'h01, 3'h0, 1'b0, 8'h00, 11'h000, 8'h01, 8'h00);
    run(cbx_pkg::CBX_OP_SKIP_SET, 1'b1, 7'h01, 3'h0, 1'b0, 8'h00, 11'h000, 8'h01, 8'h00);
    // watchdog kick twice in a row
    repeat (2) run(cbx_pkg::CBX_OP_WDT_KICK, 1'b1, 7'h00, 3'h0, 1'b0, 8'h00, 11'h000, 8'h00,
                   8'h00);
    // calls: top target with latch field 11, squashed call, low target with field 00
    run(cbx_pkg::CBX_OP_CALL, 1'b1, 7'h00, 3'h0, 1'b0, 8'h00, 11'h7ff, 8'h00, 8'h18);
    run(cbx_pkg::CBX_OP_CALL, 1'b1, 7'h00, 3'h0, 1'b0, 8'h00, 11'h123, 8'h00, 8'h08);
    run(cbx_pkg::CBX_OP_CALL, 1'b1, 7'h00, 3'h0, 1'b0, 8'h00, 11'h000, 8'h00, 8'he7);
    run(cbx_pkg::CBX_OP_NOP, 1'b0, 7'h00, 3'h0, 1'b0, 8'h00, 11'h000, 8'h00, 8'h00);
    run(cbx_pkg::CBX_OP_CALL, 1'b1, 7'h00, 3'h0, 1'b0, 8'h00, 11'h400, 8'h00, 8'h08);
    run(cbx_pkg::CBX_OP_SET_BIT, 1'b1, 7'h40, 3'h2, 1'b0, 8'h00, 11'h000, 8'h00, 8'h00);
    run(cbx_pkg::CBX_OP_SET_BIT, 1'b1, 7'h41, 3'h3, 1'b0, 8'h00, 11'h000, 8'h00, 8'h00);
    // reset in mid-run, then a call straight after release
    do_reset(2);
    run(cbx_pkg::CBX_OP_CALL, 1'b1, 7'h00, 3'h0, 1'b0, 8'h00, 11'h2aa, 8'h00, 8'h10);
    run(cbx_pkg::CBX_OP_AND_IMM, 1'b1, 7'h00, 3'h0, 1'b0, 8'h0f, 11'h000, 8'h00, 8'h00);
    run(cbx_pkg::CBX_OP_AND_IMM, 1'b1, 7'h00, 3'h0, 1'b0, 8'h0f, 11'h000, 8'h00, 8'h00);
    conclude();
  end

endmodule

/* File: verilog/cbx_bit_unit.sv */
// bit/logic arithmetic unit: bit set, AND, bit test and zero detect
`timescale 1ns/1ps

module cbx_bit_unit #(
  parameter int DW = 8
) (
  input  wire logic [DW-1:0] acc,
  input  wire logic [DW-1:0] file_val,
  input  wire logic [DW-1:0] literal,
  input  wire logic [2:0]    bit_sel,
  output logic      [DW-1:0] set_res,
  output logic      [DW-1:0] and_imm_res,
  output logic      [DW-1:0] and_file_res,
  output logic               bit_val,
  output logic               imm_zero,
  output logic               file_zero
);

  // one-hot mask built per bit so any width stays a single loop
  logic [DW-1:0] mask;
  genvar i;
  generate
    for (i = 0; i < DW; i++) begin : g_mask
      assign mask[i] = (bit_sel == 3'(i));
    end
  endgenerate

  // pure combinational results
  assign set_res      = file_val | mask;     // [RULE1]
  assign and_imm_res  = acc & literal;       // [RULE2]
  assign and_file_res = acc & file_val;      // [RULE3]
  assign bit_val      = |(file_val & mask);
  assign imm_zero     = (and_imm_res == '0);  // [RULE13]
  assign file_zero    = (and_file_res == '0); // [RULE13]

endmodule

/* File: verilog/cbx_exec.sv */
// execute stage for bit set, bit test skips, AND ops, watchdog kick and call
`timescale 1ns/1ps

module cbx_exec (
  input  wire logic                        clk,
  input  wire logic                        rst,
  // decoded instruction from fetch, one per instruction cycle
  input  wire logic                        instr_valid,
  input  wire cbx_pkg::cbx_op_e            instr_op,
  input  wire logic [cbx_pkg::FADDR_W-1:0] instr_faddr,
  input  wire logic [cbx_pkg::BIT_W-1:0]   instr_bit,
  input  wire logic                        instr_dest,
  input  wire logic [cbx_pkg::DATA_W-1:0]  instr_literal,
  input  wire logic [cbx_pkg::TARGET_W-1:0] instr_target,
  // file register read port, same cycle
  output logic      [cbx_pkg::FADDR_W-1:0] file_raddr,
  input  wire logic [cbx_pkg::DATA_W-1:0]  file_rdata,
  // file register write port
  output logic                             file_we,
  output logic      [cbx_pkg::FADDR_W-1:0] file_waddr,
  output logic      [cbx_pkg::DATA_W-1:0]  file_wdata,
  // upper program counter bits latch
  input  wire logic [cbx_pkg::DATA_W-1:0]  upper_jump_latch,
  // accumulator write-back from instructions executed elsewhere
  input  wire logic                        acc_load,
  input  wire logic [cbx_pkg::DATA_W-1:0]  acc_load_data,
  // architectural state
  output logic      [cbx_pkg::DATA_W-1:0]  acc_q,
  output logic      [cbx_pkg::PC_W-1:0]    pc_q,
  output logic                             result_null_flag_q,
  output logic                             watchdog_expired_flag_q,
  output logic                             sleep_entered_flag_q,
  // hardware stack push
  output logic                             stack_push,
  output logic      [cbx_pkg::PC_W-1:0]    stack_top,
  // watchdog clears
  output logic                             watchdog_counter_clr,
  output logic                             watchdog_prescaler_clr,
  output logic [cbx_pkg::DATA_W-1:0]       watchdog_counter_load,
  // high while the current cycle is a forced no-op
  output logic                             flush_q
);

  // ---------------------------------------------------------------------------
  // datapath results
  // ---------------------------------------------------------------------------
  logic [cbx_pkg::DATA_W-1:0] set_res;
  logic [cbx_pkg::DATA_W-1:0] and_imm_res;
  logic [cbx_pkg::DATA_W-1:0] and_file_res;
  logic                       bit_val;
  logic                       imm_zero;
  logic                       file_zero;

  cbx_bit_unit #(
    .DW (cbx_pkg::DATA_W)
  ) u_bit (
    .acc          (acc_q),
    .file_val     (file_rdata),
    .literal      (instr_literal),
    .bit_sel      (instr_bit),
    .set_res      (set_res),
    .and_imm_res  (and_imm_res),
    .and_file_res (and_file_res),
    .bit_val      (bit_val),
    .imm_zero     (imm_zero),
    .file_zero    (file_zero)
  );

  // ---------------------------------------------------------------------------
  // execute qualifier and skip decision
  // ---------------------------------------------------------------------------
  // an instruction in a flushed slot is discarded entirely
  logic exec;
  logic skip_taken;
  logic is_call;
  logic next_flush;

  assign exec       = instr_valid && !flush_q;                   // [RULE12]
  assign is_call    = exec && (instr_op == cbx_pkg::CBX_OP_CALL);
  assign file_raddr = instr_faddr;

  // skip-if-clear takes on zero, skip-if-set takes on one
  always_comb begin
    skip_taken = 1'b0;
    if (exec) begin
      case (instr_op)
        cbx_pkg::CBX_OP_SKIP_CLR: skip_taken = !bit_val;         // [RULE4]
        cbx_pkg::CBX_OP_SKIP_SET: skip_taken = bit_val;          // [RULE5]
        default:                  skip_taken = 1'b0;
      endcase
    end
  end

  assign next_flush = skip_taken || is_call;                     // [RULE11]

  // ---------------------------------------------------------------------------
  // no-op slot tracker
  // ---------------------------------------------------------------------------
  // the slot after a redirect or taken skip is squashed, never chained
  always_ff @(posedge clk) begin
    if (rst) begin
      flush_q <= 1'b0;
    end else if (instr_valid || flush_q) begin
      flush_q <= next_flush;                                     // [RULE12]
    end
  end

  // ---------------------------------------------------------------------------
  // accumulator
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= cbx_pkg::ACC_RST;
    end else if (exec) begin
      case (instr_op)
        cbx_pkg::CBX_OP_AND_IMM:  acc_q <= and_imm_res;          // [RULE2]
        cbx_pkg::CBX_OP_AND_FILE: begin
          if (!instr_dest) begin
            acc_q <= and_file_res;                               // [RULE3]
          end
        end
        default: ;
      endcase
    end else if (acc_load && !flush_q) begin
      // write-back from a squashed slot is dropped with the slot
      acc_q <= acc_load_data;
    end
  end

  // ---------------------------------------------------------------------------
  // zero flag; other instructions here leave it alone
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      result_null_flag_q <= 1'b0;
    end else if (exec) begin
      case (instr_op)
        cbx_pkg::CBX_OP_AND_IMM:  result_null_flag_q <= imm_zero;   // [RULE13]
        cbx_pkg::CBX_OP_AND_FILE: result_null_flag_q <= file_zero;  // [RULE13]
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // file register write port, registered
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      file_we    <= 1'b0;
      file_waddr <= '0;
      file_wdata <= '0;
    end else begin
      file_we    <= 1'b0;
      file_waddr <= instr_faddr;
      if (exec && instr_op == cbx_pkg::CBX_OP_SET_BIT) begin
        file_we    <= 1'b1;
        file_wdata <= set_res;                                   // [RULE1]
      end else if (exec && instr_op == cbx_pkg::CBX_OP_AND_FILE && instr_dest) begin
        file_we    <= 1'b1;
        file_wdata <= and_file_res;                              // [RULE3]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // watchdog kick: counter, prescaler and active-low status bits
  // ---------------------------------------------------------------------------
  assign watchdog_counter_load = cbx_pkg::WDT_CLR;

  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_counter_clr   <= 1'b0;
      watchdog_prescaler_clr <= 1'b0;
    end else begin
      // both clears in the same pulse so prescaler never lags counter
      watchdog_counter_clr   <= exec && instr_op == cbx_pkg::CBX_OP_WDT_KICK;  // [RULE6]
      watchdog_prescaler_clr <= exec && instr_op == cbx_pkg::CBX_OP_WDT_KICK;  // [RULE6]
    end
  end

  // flags rest at one (inactive); only outside events would drop them
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_expired_flag_q <= 1'b1;
      sleep_entered_flag_q    <= 1'b1;
    end else if (exec && instr_op == cbx_pkg::CBX_OP_WDT_KICK) begin
      watchdog_expired_flag_q <= 1'b1;                           // [RULE7]
      sleep_entered_flag_q    <= 1'b1;                           // [RULE7]
    end
  end

  // ---------------------------------------------------------------------------
  // program counter and stack push
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q <= cbx_pkg::PC_RST;
    end else if (is_call) begin
      pc_q <= {upper_jump_latch[cbx_pkg::LATCH_HI:cbx_pkg::LATCH_LO],   // [RULE10]
               instr_target};                                          // [RULE9]
    end else if (instr_valid || flush_q) begin
      pc_q <= pc_q + cbx_pkg::PC_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stack_push <= 1'b0;
      stack_top  <= '0;
    end else begin
      stack_push <= is_call;
      if (is_call) begin
        stack_top <= pc_q + cbx_pkg::PC_STEP;                    // [RULE8]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_call_target;
    @(posedge clk) disable iff (rst)
    is_call |=> pc_q == {$past(upper_jump_latch[4:3]), $past(instr_target)};
  endproperty
  a_call_target: assert property (p_call_target) else $error("call target wrong"); // [RULE9]

  property p_call_upper;
    @(posedge clk) disable iff (rst)
    is_call |=> pc_q[12:11] == $past(upper_jump_latch[4:3]);
  endproperty
  a_call_upper: assert property (p_call_upper) else $error("call upper bits wrong"); // [RULE10]

  property p_call_push;
    @(posedge clk) disable iff (rst)
    is_call |=> stack_push && stack_top == $past(pc_q) + 13'h0001;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong"); // [RULE8]

  property p_call_two;
    @(posedge clk) disable iff (rst)
    is_call |=> flush_q && !exec;
  endproperty
  a_call_two: assert property (p_call_two) else $error("call not two cycles"); // [RULE11]

  property p_skip_clr;
    @(posedge clk) disable iff (rst)
    exec && instr_op == cbx_pkg::CBX_OP_SKIP_CLR |=> flush_q == !$past(bit_val);
  endproperty
  a_skip_clr: assert property (p_skip_clr) else $error("skip clear wrong"); // [RULE4]

  property p_skip_set;
    @(posedge clk) disable iff (rst)
    exec && instr_op == cbx_pkg::CBX_OP_SKIP_SET |=> flush_q == $past(bit_val);
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip set wrong"); // [RULE5]

  property p_flush_nop;
    @(posedge clk) disable iff (rst)
    flush_q |=> !file_we && !stack_push && !watchdog_counter_clr && $stable(acc_q);
  endproperty
  a_flush_nop: assert property (p_flush_nop) else $error("flushed slot had effect"); // [RULE12]

  property p_set_bit;
    @(posedge clk) disable iff (rst)
    exec && instr_op == cbx_pkg::CBX_OP_SET_BIT |=>
      file_we && file_wdata[$past(instr_bit)] && $stable(result_null_flag_q);
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set wrong"); // [RULE1]

  property p_and_imm;
    @(posedge clk) disable iff (rst)
    exec && instr_op == cbx_pkg::CBX_OP_AND_IMM |=>
      acc_q == ($past(acc_q) & $past(instr_literal)) && result_null_flag_q == (acc_q == 8'h00);
  endproperty
  a_and_imm: assert property (p_and_imm) else $error("and literal wrong"); // [RULE2]

  property p_and_file;
    @(posedge clk) disable iff (rst)
    exec && instr_op == cbx_pkg::CBX_OP_AND_FILE && instr_dest |=>
      file_we && file_wdata == ($past(acc_q) & $past(file_rdata)) && $stable(acc_q);
  endproperty
  a_and_file: assert property (p_and_file) else $error("and file wrong"); // [RULE3]

  property p_zero;
    @(posedge clk) disable iff (rst)
    exec && instr_op == cbx_pkg::CBX_OP_AND_FILE |=>
      result_null_flag_q == (($past(acc_q) & $past(file_rdata)) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RULE13]

  property p_kick;
    @(posedge clk) disable iff (rst)
    exec && instr_op == cbx_pkg::CBX_OP_WDT_KICK |=>
      watchdog_counter_clr && watchdog_prescaler_clr ##1
      (!watchdog_counter_clr || $past(exec && instr_op == cbx_pkg::CBX_OP_WDT_KICK));
  endproperty
  a_kick: assert property (p_kick) else $error("watchdog clear wrong"); // [RULE6]

  property p_kick_flags;
    @(posedge clk) disable iff (rst)
    exec && instr_op == cbx_pkg::CBX_OP_WDT_KICK |=>
      watchdog_expired_flag_q && sleep_entered_flag_q;
  endproperty
  a_kick_flags: assert property (p_kick_flags) else $error("kick flags wrong"); // [RULE7]

  c_call:     cover property (@(posedge clk) disable iff (rst) is_call);
  c_skip:     cover property (@(posedge clk) disable iff (rst) skip_taken);
  c_no_skip:  cover property (@(posedge clk) disable iff (rst)
                exec && instr_op == cbx_pkg::CBX_OP_SKIP_SET && !bit_val);
  c_and_zero: cover property (@(posedge clk) disable iff (rst)
                exec && instr_op == cbx_pkg::CBX_OP_AND_IMM && imm_zero);

endmodule

/* File: verilog/cbx_pkg.sv */
// package: constants, opcodes and field layout for the bit/logic/call execute block
// -----------------------------------------------------------------------------
// How it works
// RULE1 - set_bit_op forces chosen bit of addressed file register high, flags untouched.
// RULE2 - and_immediate_op ANDs accumulator with 8-bit literal, result to accumulator, zero flag only.
// RULE3 - and_file_op ANDs accumulator with file; destination bit picks accumulator or file.
// RULE4 - skip_if_bit_clear_op: bit zero discards next instruction as no-op, two cycles.
// RULE5 - skip_if_bit_set_op: bit one discards next instruction as no-op, two cycles.
// RULE6 - watchdog_kick_op clears watchdog_counter and its prescaler together.
// RULE7 - watchdog_kick_op sets both active-low expired and sleep flags to one.
// RULE8 - call pushes program counter plus one onto stack_top.
// RULE9 - call loads 11-bit target into program counter bits 10 to 0.
// RULE10 - call fills program counter bits 12 to 11 from upper_jump_latch bits 4 to 3.
// RULE11 - call takes two instruction cycles since the program counter is redirected.
// RULE12 - second cycle after branch or taken skip behaves as a no-operation.
// RULE13 - zero flag set when 8-bit result is zero, cleared otherwise.
// -----------------------------------------------------------------------------
package cbx_pkg;

  // ---------------------------------------------------------------------------
  // widths and ranges
  // ---------------------------------------------------------------------------
  localparam int PC_W      = 13;
  localparam int DATA_W    = 8;
  localparam int FADDR_W   = 7;   // file address 0..127
  localparam int BIT_W     = 3;   // bit index 0..7
  localparam int TARGET_W  = 11;  // call target 0..2047
  localparam int LATCH_HI  = 4;   // upper_jump_latch field top
  localparam int LATCH_LO  = 3;   // upper_jump_latch field bottom

  // ---------------------------------------------------------------------------
  // reset values, watchdog kick load value and program counter step
  // ---------------------------------------------------------------------------
  localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic [DATA_W-1:0] WDT_CLR  = 8'h00;   // value loaded by watchdog kick
  localparam logic [PC_W-1:0]   PC_STEP  = 13'h0001;

  // ---------------------------------------------------------------------------
  // operations handled here, as decoded by the fetch stage
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CBX_OP_NOP,
    CBX_OP_SET_BIT,
    CBX_OP_AND_IMM,
    CBX_OP_AND_FILE,
    CBX_OP_SKIP_CLR,
    CBX_OP_SKIP_SET,
    CBX_OP_WDT_KICK,
    CBX_OP_CALL
  } cbx_op_e;

endpackage
